// File: tb/sfr_asserts.sv
/* checker for the message router and dispatcher ports.
   assumes a bind to sfr_router with its default widths. */
`timescale 1ns/1ns
`default_nettype none
module sfr_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        msg_valid,
  input wire logic        msg_ready,
  input wire logic [3:0]  msg_target_function_code,
  input wire logic [10:0] unit_valid,
  input wire logic [10:0] unit_ready,
  input wire logic        msg_dropped,
  input wire logic [3:0]  req_grant,
  input wire logic        init_we,
  input wire logic        thread_start
);
  // ****************
  // helper terms
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire       take = msg_valid && msg_ready;  // message taken
  wire [3:0] code = msg_target_function_code;
  wire       bad  = code < 4'h2 || code > 4'hd;  // null or reserved
  // ****************
  // properties
  // ****************
  sequence s_load;  // two register writes, then the start pulse
    init_we ##1 init_we ##1 thread_start;
  endsequence
  property p_drop;
    take && bad |=> msg_dropped && unit_valid == 11'h000;
  endproperty
  a_drop: assert property (p_drop) else $error("bad target reached a unit");
  property p_tex;
    take && code == 4'h2 |=> unit_valid == 11'h001 && !msg_dropped;
  endproperty
  a_tex: assert property (p_tex) else $error("texture route wrong");
  property p_dcache;
    take && (code == 4'ha || code == 4'hc) |=> unit_valid == 11'h100;
  endproperty
  a_dcache: assert property (p_dcache) else $error("data cache route wrong");
  property p_creator;
    take && code == 4'h7 |=> unit_valid == 11'h020;
  endproperty
  a_creator: assert property (p_creator) else $error("creator route wrong");
  property p_hold;
    unit_valid != 11'h000 && (unit_valid & unit_ready) == 11'h000
      |-> !msg_ready ##1 $stable(unit_valid);
  endproperty
  a_hold: assert property (p_hold) else $error("unit request not held");
  property p_onehot;
    $onehot0(unit_valid) && $onehot0(req_grant);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one line");
  property p_gap;
    req_grant != 4'h0 |=> req_grant == 4'h0 [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("grant during load");
  property p_load;
    req_grant != 4'h0 |-> ##2 s_load;
  endproperty
  a_load: assert property (p_load) else $error("load order wrong");
endmodule // sfr_asserts
`default_nettype wire

// File: tb/sfr_far_model.sv
/* far side model: shared function units and execution units.
   assumes router outputs change on the rising edge. */
`timescale 1ns/1ns
`default_nettype none
module sfr_far_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        stall,
  input  wire logic [10:0] unit_valid,
  input  wire logic [2:0]  unit_slot,
  input  wire logic        thread_start,
  input  wire logic [2:0]  thread_slot,
  output var  logic [10:0] unit_ready,
  output var  logic        reply_done,
  output var  logic [2:0]  reply_slot,
  output var  logic        thread_end,
  output var  logic [2:0]  thread_end_slot
);
  // ****************
  // capture
  // ****************
  logic       took;   // a unit accepted a message
  logic [2:0] tslot;  // its slot
  logic [1:0] run;    // started threads live two cycles
  logic [5:0] rslot;  // their slots
  integer     seed_m; // ready pattern seed
  initial seed_m = 32'h27b3;
  // sample what the router shows at the edge
  always @(posedge clk)
  begin
    took  <= |(unit_valid & unit_ready);
    tslot <= unit_slot;
    run   <= {run[0], thread_start};
    rslot <= {rslot[2:0], thread_slot};
  end
  // answers move on the falling edge; idle lines toggle
  always @(negedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      unit_ready      <= 11'h000;
      reply_done      <= 1'b0;
      reply_slot      <= 3'h0;
      thread_end      <= 1'b0;
      thread_end_slot <= 3'h0;
    end
    else
    begin
      // random slowness, or a full stall on command
      unit_ready      <= (stall || $random(seed_m) % 2) ? 11'h000 : 11'h7ff;
      reply_done      <= took;
      reply_slot      <= took ? tslot : ~reply_slot;
      thread_end      <= run[1];
      thread_end_slot <= run[1] ? rslot[5:3] : ~thread_end_slot;
    end
  end
endmodule // sfr_far_model
`default_nettype wire

// File: tb/testbench.sv
/* self-checking bench for sfr_router.
   assumes the far side model and the checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rstn, msg_valid, msg_ready, msg_needs_reply, stall;
  logic [3:0]   msg_target_function_code, msg_operand_count, thread_stage;
  logic [15:0]  msg_opcode, unit_opcode;
  logic [7:0]   msg_operand_base, msg_reply_reg, unit_operand_base, unit_reply_reg;
  logic [7:0]   init_addr, slot_asleep, slot_busy;
  logic [2:0]   msg_slot, unit_slot, reply_slot, init_slot, thread_slot, thread_end_slot;
  logic [10:0]  unit_valid, unit_ready;
  logic [3:0]   unit_operand_count, req_valid, req_grant;
  logic         unit_ext_msg, msg_dropped, reply_done, init_we, thread_start, thread_end;
  logic [15:0]  req_pipeline_stage_code;
  logic [31:0]  req_reg_count, rb_payload, init_data;
  logic [127:0] req_payload;
  integer       seed, failures, samples_checked, cyc, k, last;
  logic [31:0]  r;
  logic [3:0]   g, served;
  sfr_router u_dut (.clk, .rstn, .msg_valid, .msg_ready, .msg_target_function_code,
    .msg_opcode, .msg_operand_base, .msg_operand_count, .msg_reply_reg, .msg_needs_reply,
    .msg_slot, .unit_valid, .unit_ready, .unit_opcode, .unit_operand_base,
    .unit_operand_count, .unit_reply_reg, .unit_slot, .unit_ext_msg, .msg_dropped,
    .reply_done, .reply_slot, .slot_asleep, .req_valid, .req_pipeline_stage_code,
    .req_reg_count, .req_payload, .req_grant, .rb_payload, .init_we, .init_slot,
    .init_addr, .init_data, .thread_start, .thread_slot, .thread_stage, .thread_end,
    .thread_end_slot, .slot_busy);
  sfr_far_model u_far (.clk, .rstn, .stall, .unit_valid, .unit_slot, .thread_start,
    .thread_slot, .unit_ready, .reply_done, .reply_slot, .thread_end, .thread_end_slot);
  // ****************
  // clock and timeout
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [10:0] hot(input logic [3:0] c);  // expected unit line
    if (c >= 4'h2 && c <= 4'h9) return 11'h001 << (c - 4'h2);
    if (c == 4'ha || c == 4'hc) return 11'h100;
    if (c == 4'hb) return 11'h200;
    if (c == 4'hd) return 11'h400;
    return 11'h000;
  endfunction
  function automatic logic stage_ok(input logic [3:0] c);  // known requester
    return c inside {4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // offer one message once every sleeper woke, then judge its route
  task automatic send_msg(input logic [3:0] c, input logic nr);
    logic [10:0] e;
    e = hot(c);
    @(negedge clk);
    while (slot_asleep !== 8'h00) @(negedge clk);
    msg_valid                <= 1'b1;
    msg_target_function_code <= c;
    msg_needs_reply          <= nr;
    msg_opcode               <= $random(seed);
    msg_slot                 <= $random(seed);
    msg_reply_reg            <= $random(seed);
    #1;
    // ready follows the unit answers that move on this same edge
    while (msg_ready !== 1'b1)
    begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    msg_valid <= 1'b0;
    check(unit_valid, e);
    check(msg_dropped, e == 11'h000);
    // a dropped message leaves the output fields as they were
    if (e != 11'h000)
    begin
      check(unit_opcode, msg_opcode);
      check(unit_reply_reg, msg_reply_reg);
      check({unit_operand_base, unit_operand_count, unit_slot},
            {msg_operand_base, msg_operand_count, msg_slot});
    end
    check(slot_asleep[msg_slot], nr && e != 11'h000);
    if (e == 11'h100) check(unit_ext_msg, c == 4'hc);
  endtask
  // one thread start request; reserved codes must stay refused
  task automatic dispatch(input int i, input logic [3:0] s);
    logic [31:0] pl;
    logic [7:0]  ia;
    pl = $random(seed);
    @(negedge clk);
    req_pipeline_stage_code[i*4 +: 4] <= s;
    req_payload[i*32 +: 32]           <= pl;
    rb_payload                        <= $random(seed);
    req_valid[i]                      <= 1'b1;
    #1;
    if (!stage_ok(s))
    begin
      repeat (8) @(negedge clk) check(req_grant, 4'h0);
      req_valid[i] <= 1'b0;
    end
    else
    begin
      while (req_grant[i] !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid[i] <= 1'b0;
      check(slot_busy[thread_slot], 1'b1);
      @(negedge clk);
      check({init_we, init_slot}, {1'b1, thread_slot});
      check(init_data, pl);
      ia = init_addr;
      @(negedge clk);
      check({init_we, init_data}, {1'b1, rb_payload});
      check(init_addr, ia + 8'h01);
      @(negedge clk);
      check({thread_start, thread_stage}, {1'b1, s});
    end
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {rstn, msg_valid, msg_needs_reply, stall, msg_target_function_code} = '0;
    {msg_opcode, msg_slot, msg_reply_reg, req_valid, req_pipeline_stage_code} = '0;
    {msg_operand_base, msg_operand_count, rb_payload, req_payload} = '0;
    req_reg_count = 32'h08080808;
    {failures, samples_checked, cyc, last} = '0;
    seed = 32'h27b3;
    repeat (16) @(posedge clk);
    // release off the rising edge so the async reset never races it
    @(negedge clk);
    check({unit_valid, msg_ready, req_grant, slot_busy, slot_asleep},
          {11'h000, 1'b1, 4'h0, 16'h0000});
    rstn = 1'b1;
    for (k = 0; k < 16; k++) send_msg(k[3:0], 1'b1);
    $display("test all target codes done");
    for (k = 0; k < 40; k++)
    begin
      r = $random(seed);
      msg_operand_base  <= r[15:8];
      msg_operand_count <= r[19:16];
      send_msg(r[3:0], r[4]);
    end
    $display("test random messages done");
    // drain every unit and reply first, or the stall would hang the run
    while (unit_valid !== 11'h000 || slot_asleep !== 8'h00) @(negedge clk);
    stall <= 1'b1;
    send_msg(4'h9, 1'b0);
    repeat (4) @(negedge clk) check({unit_valid, msg_ready}, {11'h080, 1'b0});
    stall <= 1'b0;
    $display("test stalled unit done");
    for (k = 0; k < 16; k++) dispatch(k % 4, k[3:0]);
    dispatch(1, 4'h7);
    $display("test stage codes done");
    served = 4'h0;
    g      = 4'h0;
    for (k = 0; k < 4; k++) req_pipeline_stage_code[k*4 +: 4] <= 4'h9;
    @(negedge clk);
    req_valid <= 4'hf;
    for (k = 0; k < 80; k++)
    begin
      @(negedge clk);
      req_valid <= req_valid & ~g;
      g = req_grant;
      if (g != 4'h0 && served != 4'h0) check($clog2(g), (last + 1) % 4);
      if (g != 4'h0) last = $clog2(g);
      served = served | g;
    end
    check(served, 4'hf);
    $display("test arbitration done");
    print_verdict();
  end
endmodule // testbench
bind sfr_router sfr_asserts u_chk (.clk, .rstn, .msg_valid, .msg_ready,
  .msg_target_function_code, .unit_valid, .unit_ready, .msg_dropped, .req_grant,
  .init_we, .thread_start);
`default_nettype wire

// File: verilog/sfr_consts.vh
/*
  constants for the shared function message router: function codes,
  pipeline stage codes, widths and dispatcher counts.
  assumes it is included by its bare name from the router module.
*/
// Summary of operation
// - message holds operands, target, opcode, reply register
// - decode low target codes two through six
// - decode target codes seven to d; rest reserved
// - identify requesting pipeline stages by four-bit code
// - thread creator is both target and requester
// - both data cache codes reach one unit
// - arbitrate concurrent thread start requests
// - bind granted thread to free slot, allocate registers
// - load thread registers from stage and return buffer
// - sleep issuing thread until reply written back
// - thread creator spawns for front end and general work
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH
`define SFR_TARGET_NONE              4'h0
`define SFR_TARGET_TEXTURE_UNIT      4'h2
`define SFR_TARGET_MSG_GATEWAY       4'h3
`define SFR_TARGET_TEXTURE_CACHE     4'h4
`define SFR_TARGET_RENDER_CACHE      4'h5
`define SFR_TARGET_RETURN_BUFFER     4'h6
`define SFR_TARGET_THREAD_CREATOR    4'h7
`define SFR_TARGET_MOTION_ESTIMATOR  4'h8
`define SFR_TARGET_CONSTANT_CACHE    4'h9
`define SFR_TARGET_DATA_CACHE_ZERO   4'ha
`define SFR_TARGET_PIXEL_INTERP      4'hb
`define SFR_TARGET_DATA_CACHE_ONE    4'hc
`define SFR_TARGET_CHECK_REFINE      4'hd
`define SFR_STAGE_NONE               4'h0
`define SFR_STAGE_HULL               4'h4
`define SFR_STAGE_DOMAIN             4'h5
`define SFR_STAGE_THREAD_CREATOR     4'h7
`define SFR_STAGE_VERTEX             4'h9
`define SFR_STAGE_COMMAND_STREAM     4'ha
`define SFR_STAGE_VERTEX_FETCH       4'hb
`define SFR_STAGE_GEOMETRY           4'hc
`define SFR_STAGE_STRIP_FAN          4'he
`define SFR_STAGE_WINDOW_MASK        4'hf
// unit index on the one-hot message output
`define SFR_UNIT_TEXTURE             0
`define SFR_UNIT_GATEWAY             1
`define SFR_UNIT_TEXTURE_CACHE       2
`define SFR_UNIT_RENDER_CACHE        3
`define SFR_UNIT_RETURN_BUFFER       4
`define SFR_UNIT_THREAD_CREATOR      5
`define SFR_UNIT_MOTION_EST          6
`define SFR_UNIT_CONSTANT_CACHE      7
`define SFR_UNIT_DATA_CACHE          8
`define SFR_UNIT_PIXEL_INTERP        9
`define SFR_UNIT_CHECK_REFINE        10
`define SFR_NUM_UNITS                11
// dispatcher defaults
`define SFR_NUM_SLOTS                8
`define SFR_SLOT_BITS                3
`define SFR_REGS_TOTAL               128
`define SFR_REG_BITS                 8
`define SFR_NUM_REQ                  4
// dispatcher states
`define SFR_DS_IDLE                  2'h0
`define SFR_DS_LOAD_STAGE            2'h1
`define SFR_DS_LOAD_RETURN           2'h2
`define SFR_DS_START                 2'h3
`endif

// File: verilog/sfr_router.v
/*
  shared function message router and thread dispatcher in one module.
  assumes one clock, inputs synchronous to clk, and that execution units
  and shared function units obey valid/ready on each port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sfr_consts.vh"

module sfr_router #(
  parameter NUM_SLOTS  = `SFR_NUM_SLOTS,   // hardware thread slots
  parameter SLOT_BITS  = `SFR_SLOT_BITS,   // slot index width
  parameter REGS_TOTAL = `SFR_REGS_TOTAL,  // register space per unit
  parameter REG_BITS   = `SFR_REG_BITS,    // register address width
  parameter NUM_REQ    = `SFR_NUM_REQ,     // thread start requesters
  parameter DATA_W     = 32,               // payload / operand width
  parameter OP_W       = 16                // function specific opcode
)(
  input  wire                      clk,
  input  wire                      rstn,
  // message in from issuing threads
  input  wire                      msg_valid,
  output wire                      msg_ready,
  input  wire [3:0]                msg_target_function_code,
  input  wire [OP_W-1:0]           msg_opcode,
  input  wire [REG_BITS-1:0]       msg_operand_base,
  input  wire [3:0]                msg_operand_count,
  input  wire [REG_BITS-1:0]       msg_reply_reg,
  input  wire                      msg_needs_reply,
  input  wire [SLOT_BITS-1:0]      msg_slot,
  // message out to shared function units
  output reg  [`SFR_NUM_UNITS-1:0] unit_valid,
  input  wire [`SFR_NUM_UNITS-1:0] unit_ready,
  output reg  [OP_W-1:0]           unit_opcode,
  output reg  [REG_BITS-1:0]       unit_operand_base,
  output reg  [3:0]                unit_operand_count,
  output reg  [REG_BITS-1:0]       unit_reply_reg,
  output reg  [SLOT_BITS-1:0]      unit_slot,
  output reg                       unit_ext_msg,
  output reg                       msg_dropped,
  // reply writeback completion from units
  input  wire                      reply_done,
  input  wire [SLOT_BITS-1:0]      reply_slot,
  output wire [NUM_SLOTS-1:0]      slot_asleep,
  // thread start requests from pipeline stages
  input  wire [NUM_REQ-1:0]        req_valid,
  input  wire [NUM_REQ*4-1:0]      req_pipeline_stage_code,
  input  wire [NUM_REQ*REG_BITS-1:0] req_reg_count,
  input  wire [NUM_REQ*DATA_W-1:0] req_payload,
  output wire [NUM_REQ-1:0]        req_grant,
  // return buffer payload
  input  wire [DATA_W-1:0]         rb_payload,
  // register initialisation write port
  output reg                       init_we,
  output reg  [SLOT_BITS-1:0]      init_slot,
  output reg  [REG_BITS-1:0]       init_addr,
  output reg  [DATA_W-1:0]         init_data,
  // thread start and retirement
  output reg                       thread_start,
  output reg  [SLOT_BITS-1:0]      thread_slot,
  output reg  [3:0]                thread_stage,
  input  wire                      thread_end,
  input  wire [SLOT_BITS-1:0]      thread_end_slot,
  output wire [NUM_SLOTS-1:0]      slot_busy
);

  // ****************************************************************
  // target decode
  // ****************************************************************

  // unit index for a target code, or -1 if null/reserved
  function integer sfr_unit;
    input [3:0] code;
    begin
      case (code)
        `SFR_TARGET_TEXTURE_UNIT:     sfr_unit = `SFR_UNIT_TEXTURE;
        `SFR_TARGET_MSG_GATEWAY:      sfr_unit = `SFR_UNIT_GATEWAY;
        `SFR_TARGET_TEXTURE_CACHE:    sfr_unit = `SFR_UNIT_TEXTURE_CACHE;
        `SFR_TARGET_RENDER_CACHE:     sfr_unit = `SFR_UNIT_RENDER_CACHE;
        `SFR_TARGET_RETURN_BUFFER:    sfr_unit = `SFR_UNIT_RETURN_BUFFER;
        `SFR_TARGET_THREAD_CREATOR:   sfr_unit = `SFR_UNIT_THREAD_CREATOR;
        `SFR_TARGET_MOTION_ESTIMATOR: sfr_unit = `SFR_UNIT_MOTION_EST;
        `SFR_TARGET_CONSTANT_CACHE:   sfr_unit = `SFR_UNIT_CONSTANT_CACHE;
        `SFR_TARGET_DATA_CACHE_ZERO:  sfr_unit = `SFR_UNIT_DATA_CACHE;
        `SFR_TARGET_PIXEL_INTERP:     sfr_unit = `SFR_UNIT_PIXEL_INTERP;
        `SFR_TARGET_DATA_CACHE_ONE:   sfr_unit = `SFR_UNIT_DATA_CACHE;
        `SFR_TARGET_CHECK_REFINE:     sfr_unit = `SFR_UNIT_CHECK_REFINE;
        default:                      sfr_unit = -1;
      endcase
    end
  endfunction

  // known requesting stage codes, the rest are refused
  function stage_ok;
    input [3:0] code;
    begin
      case (code)
        `SFR_STAGE_HULL, `SFR_STAGE_DOMAIN, `SFR_STAGE_THREAD_CREATOR,
        `SFR_STAGE_VERTEX, `SFR_STAGE_COMMAND_STREAM, `SFR_STAGE_VERTEX_FETCH,
        `SFR_STAGE_GEOMETRY, `SFR_STAGE_STRIP_FAN,
        `SFR_STAGE_WINDOW_MASK:       stage_ok = 1'b1;
        default:                      stage_ok = 1'b0;
      endcase
    end
  endfunction

  integer          dec_idx;                 // decoded unit index
  wire             out_busy = |unit_valid;  // output register holds a message
  wire             out_free = !out_busy || |(unit_valid & unit_ready);
  assign msg_ready = out_free;

  always @*
  begin
    dec_idx = sfr_unit(msg_target_function_code);
  end

  // ****************************************************************
  // message output register
  // ****************************************************************

  // one-entry skid: a new message loads as the old one leaves
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      unit_valid         <= {`SFR_NUM_UNITS{1'b0}};
      unit_opcode        <= {OP_W{1'b0}};
      unit_operand_base  <= {REG_BITS{1'b0}};
      unit_operand_count <= 4'h0;
      unit_reply_reg     <= {REG_BITS{1'b0}};
      unit_slot          <= {SLOT_BITS{1'b0}};
      unit_ext_msg       <= 1'b0;
      msg_dropped        <= 1'b0;
    end
    else
    begin
      msg_dropped <= 1'b0;
      if (out_free)
      begin
        unit_valid <= {`SFR_NUM_UNITS{1'b0}};
        if (msg_valid && dec_idx >= 0)
        begin
          unit_valid[dec_idx] <= 1'b1;
          unit_opcode         <= msg_opcode;
          unit_operand_base   <= msg_operand_base;
          unit_operand_count  <= msg_operand_count;
          unit_reply_reg      <= msg_reply_reg;
          unit_slot           <= msg_slot;
          unit_ext_msg        <= (msg_target_function_code ==
                                  `SFR_TARGET_DATA_CACHE_ONE);
        end
        else if (msg_valid)
          msg_dropped <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // reply dependency tracking
  // ****************************************************************

  reg  [NUM_SLOTS-1:0] sleep_reg;  // slot waits for a reply
  reg  [NUM_SLOTS-1:0] busy_reg;   // slot holds a resident thread
  assign slot_asleep = sleep_reg;
  assign slot_busy   = busy_reg;

  // set wins over clear when both hit one slot in a cycle
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLOTS; gs = gs + 1)
    begin : g_sleep
      wire set_s = msg_valid && out_free && msg_needs_reply && dec_idx >= 0
                   && msg_slot == gs;
      wire clr_s = reply_done && reply_slot == gs;
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          sleep_reg[gs] <= 1'b0;
        else if (set_s)
          sleep_reg[gs] <= 1'b1;
        else if (clr_s)
          sleep_reg[gs] <= 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // thread dispatcher
  // ****************************************************************

  reg  [1:0]            st_reg;            // dispatcher state
  reg  [SLOT_BITS-1:0]  rr_reg;            // round robin pointer
  reg  [SLOT_BITS-1:0]  gsel_reg;          // granted requester
  reg  [REG_BITS:0]     reg_used_reg;      // allocated register space
  reg  [REG_BITS-1:0]   reg_base [0:NUM_SLOTS-1]; // per slot base
  reg  [REG_BITS-1:0]   reg_size [0:NUM_SLOTS-1]; // per slot size
  reg  [NUM_REQ-1:0]    grant_c;
  reg                   free_found;
  reg  [SLOT_BITS-1:0]  free_slot;
  integer               i;
  integer               k;
  integer               j;                 // loop index of the clocked process only

  wire [REG_BITS-1:0] g_count = req_reg_count[gsel_reg*REG_BITS +: REG_BITS];
  wire [3:0]          g_stage = req_pipeline_stage_code[gsel_reg*4 +: 4];

  // lowest free slot and round robin pick of one valid requester
  always @*
  begin
    free_found = 1'b0;
    free_slot  = {SLOT_BITS{1'b0}};
    grant_c    = {NUM_REQ{1'b0}};
    k          = 0;
    for (i = NUM_SLOTS - 1; i >= 0; i = i - 1)
      if (!busy_reg[i])
      begin
        free_found = 1'b1;
        free_slot  = i[SLOT_BITS-1:0];
      end
    if (st_reg == `SFR_DS_IDLE && free_found)
      for (i = NUM_REQ - 1; i >= 0; i = i - 1)
      begin
        k = (i + rr_reg) % NUM_REQ;
        if (req_valid[k] && stage_ok(req_pipeline_stage_code[k*4 +: 4]) &&
            ({1'b0, req_reg_count[k*REG_BITS +: REG_BITS]} + reg_used_reg
             <= REGS_TOTAL))
          grant_c = {{(NUM_REQ-1){1'b0}}, 1'b1} << k;
      end
  end
  assign req_grant = grant_c;

  // grant, bind, load payloads, start
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg       <= `SFR_DS_IDLE;
      rr_reg       <= {SLOT_BITS{1'b0}};
      gsel_reg     <= {SLOT_BITS{1'b0}};
      reg_used_reg <= {(REG_BITS+1){1'b0}};
      busy_reg     <= {NUM_SLOTS{1'b0}};
      init_we      <= 1'b0;
      init_slot    <= {SLOT_BITS{1'b0}};
      init_addr    <= {REG_BITS{1'b0}};
      init_data    <= {DATA_W{1'b0}};
      thread_start <= 1'b0;
      thread_slot  <= {SLOT_BITS{1'b0}};
      thread_stage <= 4'h0;
      for (j = 0; j < NUM_SLOTS; j = j + 1)
      begin
        reg_base[j] <= {REG_BITS{1'b0}};
        reg_size[j] <= {REG_BITS{1'b0}};
      end
    end
    else
    begin
      init_we      <= 1'b0;
      thread_start <= 1'b0;
      // retirement frees slot; simple bump allocator reclaims when empty
      if (thread_end && busy_reg[thread_end_slot])
      begin
        busy_reg[thread_end_slot] <= 1'b0;
        if ((busy_reg & ~({{(NUM_SLOTS-1){1'b0}}, 1'b1} << thread_end_slot))
            == {NUM_SLOTS{1'b0}} && st_reg == `SFR_DS_IDLE && !(|grant_c))
          reg_used_reg <= {(REG_BITS+1){1'b0}};
      end
      case (st_reg)
        `SFR_DS_IDLE:
        begin
          for (j = 0; j < NUM_REQ; j = j + 1)
            if (grant_c[j])
            begin
              gsel_reg <= j[SLOT_BITS-1:0];
              rr_reg   <= j[SLOT_BITS-1:0] + 1'b1;
              st_reg   <= `SFR_DS_LOAD_STAGE;
            end
          if (|grant_c)
          begin
            busy_reg[free_slot] <= 1'b1;
            thread_slot         <= free_slot;
          end
        end
        `SFR_DS_LOAD_STAGE:
        begin
          reg_base[thread_slot] <= reg_used_reg[REG_BITS-1:0];
          reg_size[thread_slot] <= g_count;
          reg_used_reg <= reg_used_reg + {1'b0, g_count};
          init_we   <= 1'b1;
          init_slot <= thread_slot;
          init_addr <= reg_used_reg[REG_BITS-1:0];
          init_data <= req_payload[gsel_reg*DATA_W +: DATA_W];
          st_reg    <= `SFR_DS_LOAD_RETURN;
        end
        `SFR_DS_LOAD_RETURN:
        begin
          init_we   <= 1'b1;
          init_addr <= reg_base[thread_slot] + {{(REG_BITS-1){1'b0}}, 1'b1};
          init_data <= rb_payload;
          st_reg    <= `SFR_DS_START;
        end
        `SFR_DS_START:
        begin
          thread_start <= 1'b1;
          thread_stage <= g_stage;
          st_reg       <= `SFR_DS_IDLE;
        end
        default:
          st_reg <= `SFR_DS_IDLE;
      endcase
    end
  end

endmodule // sfr_router
`default_nettype wire
